/* File: hdl/evt_pkg.sv */
// Package: register map, field layout and timing constants of the event unit
package evt_pkg;
    localparam int CH = 32;
    localparam int AW = 8;
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_WIDTH = 8'h04;
    localparam logic [7:0] OFF_CH_EN = 8'h08;
    localparam logic [7:0] OFF_PAT_LVL = 8'h0C;
    localparam logic [7:0] OFF_PAT_EDGE = 8'h10;
    localparam logic [7:0] OFF_PAT_VAL = 8'h14;
    localparam logic [7:0] OFF_COS_EN = 8'h18;
    localparam logic [7:0] OFF_STATUS = 8'h1C;
    localparam logic [7:0] OFF_COS_LATCH = 8'h20;
    localparam logic [7:0] OFF_INPUTS = 8'h24;
    // CTRL fields
    localparam int CTRL_PIN0_SEL = 0;
    localparam int CTRL_PIN1_SEL = 1;
    localparam int CTRL_PAT_ON = 2;
    localparam int CTRL_COS_ON = 3;
    localparam int CTRL_HS_IN_ON = 4;
    localparam int CTRL_HS_OUT_ON = 5;
    localparam int CTRL_HS_GO = 6;
    localparam int CTRL_W = 7;
    // STATUS fields, write one to clear bits 0 and 1
    localparam int ST_PAT = 0;
    localparam int ST_COS = 1;
    localparam int ST_IN_RDY = 2;
    localparam int ST_OUT_BUSY = 3;
    localparam int ST_HS_RUN = 4;
    // Reset values
    localparam logic [15:0] WIDTH_RST = 16'h0001;
    localparam logic [31:0] WORD_RST = 32'h0000_0000;
    // Pulse width unit and minimum count
    localparam int UNIT_NS = 8;
    localparam logic [15:0] WIDTH_MIN = 16'h0001;
    // Condition encoding (edge,val): 00 low, 01 high, 10 fall, 11 rise
    // Bus transfer type that starts a single transfer
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
endpackage

/* File: hdl/pattern_match_cos_event_unit.sv */
// Pattern-match and change-of-state event unit with handshake lines
module pattern_match_cos_event_unit (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HSEL,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic [31:0] DATA_IN,
    output logic [1:0] FUNCTION_PIN,
    output logic PATTERN_IRQ,
    output logic COS_IRQ,
    input wire logic IN_REQUEST,
    output logic IN_ACKNOWLEDGE,
    input wire logic IN_HANDSHAKE_TRIGGER,
    output logic OUT_REQUEST,
    input wire logic OUT_ACKNOWLEDGE
);

    ////////////////////////////////////////////////////////////////////////
    // Registers
    logic [evt_pkg::CTRL_W-1:0] ctrl;
    logic [15:0] width;
    logic [31:0] ch_en;
    logic [31:0] pat_lvl;
    logic [31:0] pat_edge;
    logic [31:0] pat_val;
    logic [31:0] cos_en;
    logic [31:0] cos_latch;
    logic [31:0] cur;
    logic [31:0] prev;
    logic cur_ok;
    logic prev_ok;
    logic pat_flag;
    logic cos_flag;
    logic in_rdy;
    logic in_req_d;
    logic hs_run;
    logic [7:0] wr_addr;
    logic wr_pend;
    logic rd_clr_pat;
    logic rd_clr_cos;
    logic [31:0] ch_ok;
    logic pat_hit;
    logic cos_hit;
    logic [1:0] pulse_on;

    ////////////////////////////////////////////////////////////////////////
    // Input sampling, one sample per clock
    // Edge tests wait for two real samples; the reset value of prev is none
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            cur <= evt_pkg::WORD_RST;
            prev <= evt_pkg::WORD_RST;
            cur_ok <= 1'b0;
            prev_ok <= 1'b0;
        end else begin
            cur <= DATA_IN;
            prev <= cur;
            cur_ok <= 1'b1;
            prev_ok <= cur_ok;
        end
    end

    // Per-channel condition check
    genvar g;
    generate
        for (g = 0; g < evt_pkg::CH; g++) begin : g_ch
            logic used;
            logic rise;
            logic fall;
            logic ok;
            assign used = ch_en[g] && pat_lvl[g];
            assign rise = cur[g] && !prev[g];
            assign fall = !cur[g] && prev[g];
            assign ch_ok[g] = ok;
            always_comb begin
                if (!used) begin
                    ok = 1'b1;
                end else begin
                    case ({pat_edge[g], pat_val[g]})
                        2'h0: ok = !cur[g];
                        2'h1: ok = cur[g];
                        2'h2: ok = fall;
                        2'h3: ok = rise;
                        default: ok = 1'b0;
                    endcase
                end
            end
        end
    endgenerate

    // Edge codes need a valid earlier sample; an all-ignore mask never fires
    assign pat_hit = ctrl[evt_pkg::CTRL_PAT_ON] && prev_ok && (&ch_ok)
        && |(ch_en & pat_lvl);
    assign cos_hit = ctrl[evt_pkg::CTRL_COS_ON] && prev_ok
        && |((cur ^ prev) & cos_en);

    ////////////////////////////////////////////////////////////////////////
    // Change latch
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            cos_latch <= evt_pkg::WORD_RST;
        end else if (cos_hit) begin
            cos_latch <= cur;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pulse shapers, one per function pin
    generate
        for (g = 0; g < 2; g++) begin : g_pin
            logic src;
            logic active;
            logic [15:0] remain;
            assign src = ctrl[g] ? cos_hit : pat_hit;
            assign pulse_on[g] = active;
            always_ff @(posedge CLK or negedge RESETN) begin
                if (!RESETN) begin
                    active <= 1'b0;
                    remain <= 16'h0000;
                end else if (active) begin
                    // Clock is slower than the 8 ns unit, so each count is one cycle
                    if (remain == 16'h0000) begin
                        active <= 1'b0;
                    end else begin
                        remain <= remain - 16'h0001;
                    end
                end else if (src) begin
                    // Hits during a pulse are dropped, not queued
                    active <= 1'b1;
                    remain <= width;
                end
            end
        end
    endgenerate

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            FUNCTION_PIN <= 2'b00;
        end else begin
            FUNCTION_PIN <= pulse_on;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky interrupt flags, set wins over clear so no event is lost
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            pat_flag <= 1'b0;
        end else if (pat_hit) begin
            pat_flag <= 1'b1;
        end else if (rd_clr_pat) begin
            pat_flag <= 1'b0;
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            cos_flag <= 1'b0;
        end else if (cos_hit) begin
            cos_flag <= 1'b1;
        end else if (rd_clr_cos) begin
            cos_flag <= 1'b0;
        end
    end

    // Pins copy the flags one cycle late so they come straight from flops
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            PATTERN_IRQ <= 1'b0;
            COS_IRQ <= 1'b0;
        end else begin
            PATTERN_IRQ <= pat_flag;
            COS_IRQ <= cos_flag;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Handshake: run starts on software go or peer trigger
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            hs_run <= 1'b0;
        end else if (!(ctrl[evt_pkg::CTRL_HS_IN_ON] || ctrl[evt_pkg::CTRL_HS_OUT_ON])) begin
            hs_run <= 1'b0;
        end else if (ctrl[evt_pkg::CTRL_HS_GO] || IN_HANDSHAKE_TRIGGER) begin
            hs_run <= 1'b1;
        end
    end

    // Request delay resets low like the idle pin, so no false edge follows reset
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            in_req_d <= 1'b0;
        end else begin
            in_req_d <= IN_REQUEST;
        end
    end

    // Input side: mark word on request edge, acknowledge follows request
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            in_rdy <= 1'b0;
            IN_ACKNOWLEDGE <= 1'b0;
        end else begin
            if (hs_run && ctrl[evt_pkg::CTRL_HS_IN_ON]) begin
                IN_ACKNOWLEDGE <= IN_REQUEST;
                if (IN_REQUEST && !in_req_d) begin
                    in_rdy <= 1'b1;
                end else if (wr_pend && wr_addr == evt_pkg::OFF_INPUTS) begin
                    in_rdy <= 1'b0;
                end
            end else begin
                IN_ACKNOWLEDGE <= 1'b0;
            end
        end
    end

    // Output side: a write to the data register raises request until acknowledged
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            OUT_REQUEST <= 1'b0;
        end else if (!(hs_run && ctrl[evt_pkg::CTRL_HS_OUT_ON])) begin
            OUT_REQUEST <= 1'b0;
        end else if (OUT_REQUEST && OUT_ACKNOWLEDGE) begin
            OUT_REQUEST <= 1'b0;
        end else if (!OUT_ACKNOWLEDGE && wr_pend && wr_addr == evt_pkg::OFF_INPUTS) begin
            OUT_REQUEST <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave, zero wait states
    logic take;
    logic wr_now;
    assign take = HSEL && HREADY && HTRANS == evt_pkg::HTRANS_NONSEQ;
    assign wr_now = wr_pend;
    assign rd_clr_pat = wr_now && wr_addr == evt_pkg::OFF_STATUS && HWDATA[evt_pkg::ST_PAT];
    assign rd_clr_cos = wr_now && wr_addr == evt_pkg::OFF_STATUS && HWDATA[evt_pkg::ST_COS];

    // No wait states and no error replies; still flops so outputs stay registered
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
        end else begin
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else begin
            wr_pend <= take && HWRITE;
            if (take) begin
                wr_addr <= HADDR[7:0];
            end
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            ctrl <= '0;
            width <= evt_pkg::WIDTH_RST;
            ch_en <= evt_pkg::WORD_RST;
            pat_lvl <= evt_pkg::WORD_RST;
            pat_edge <= evt_pkg::WORD_RST;
            pat_val <= evt_pkg::WORD_RST;
            cos_en <= evt_pkg::WORD_RST;
        end else begin
            ctrl[evt_pkg::CTRL_HS_GO] <= 1'b0;
            if (wr_now) begin
                case (wr_addr)
                    evt_pkg::OFF_CTRL: ctrl <= HWDATA[evt_pkg::CTRL_W-1:0];
                    evt_pkg::OFF_WIDTH: begin
                        // Count zero would break the 16 ns floor
                        width <= (HWDATA[15:0] < evt_pkg::WIDTH_MIN) ?
                            evt_pkg::WIDTH_MIN : HWDATA[15:0];
                    end
                    evt_pkg::OFF_CH_EN: ch_en <= HWDATA;
                    evt_pkg::OFF_PAT_LVL: pat_lvl <= HWDATA;
                    evt_pkg::OFF_PAT_EDGE: pat_edge <= HWDATA;
                    evt_pkg::OFF_PAT_VAL: pat_val <= HWDATA;
                    evt_pkg::OFF_COS_EN: cos_en <= HWDATA;
                    default: ;
                endcase
            end
        end
    end

    // Read data is registered in the address phase
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            HRDATA <= evt_pkg::WORD_RST;
        end else if (take && !HWRITE) begin
            case (HADDR[7:0])
                evt_pkg::OFF_CTRL: HRDATA <= {25'h0, ctrl};
                evt_pkg::OFF_WIDTH: HRDATA <= {16'h0000, width};
                evt_pkg::OFF_CH_EN: HRDATA <= ch_en;
                evt_pkg::OFF_PAT_LVL: HRDATA <= pat_lvl;
                evt_pkg::OFF_PAT_EDGE: HRDATA <= pat_edge;
                evt_pkg::OFF_PAT_VAL: HRDATA <= pat_val;
                evt_pkg::OFF_COS_EN: HRDATA <= cos_en;
                evt_pkg::OFF_STATUS: HRDATA <= {27'h0, hs_run, OUT_REQUEST, in_rdy,
                    cos_flag, pat_flag};
                evt_pkg::OFF_COS_LATCH: HRDATA <= cos_latch;
                evt_pkg::OFF_INPUTS: HRDATA <= cur;
                default: HRDATA <= evt_pkg::WORD_RST;
            endcase
        end
    end

endmodule

/* File: tb/evt_sva.sv */
// Checker: bus, pulse, flag and handshake relations at the unit's ports
module evt_sva (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [31:0] HWDATA,
    input wire logic HSEL,
    input wire logic HREADY,
    input wire logic HREADYOUT,
    input wire logic HRESP,
    input wire logic [1:0] FUNCTION_PIN,
    input wire logic PATTERN_IRQ,
    input wire logic COS_IRQ,
    input wire logic IN_REQUEST,
    input wire logic IN_ACKNOWLEDGE,
    input wire logic OUT_REQUEST,
    input wire logic OUT_ACKNOWLEDGE
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESETN);
    logic wr;
    logic [7:0] wa;
    logic [15:0] wid;
    logic [16:0] cnt;
    logic [16:0] cnt1;
    wire logic clr_p = wr && wa == evt_pkg::OFF_STATUS && HWDATA[evt_pkg::ST_PAT];
    wire logic clr_c = wr && wa == evt_pkg::OFF_STATUS && HWDATA[evt_pkg::ST_COS];
    wire logic out_wr = wr && wa == evt_pkg::OFF_INPUTS;
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            wr <= 1'b0;
            wa <= 8'h00;
        end else begin
            wr <= HSEL && HREADY && HTRANS == evt_pkg::HTRANS_NONSEQ && HWRITE;
            wa <= HADDR[7:0];
        end
    end
    // Mirror of the width; assumes it is not rewritten mid-pulse
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN)
            wid <= evt_pkg::WIDTH_RST;
        else if (wr && wa == evt_pkg::OFF_WIDTH)
            wid <= (HWDATA[15:0] == 16'h0000) ? evt_pkg::WIDTH_MIN : HWDATA[15:0];
    end
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            cnt <= 17'h0_0000;
            cnt1 <= 17'h0_0000;
        end else begin
            cnt <= FUNCTION_PIN[0] ? cnt + 17'h0_0001 : 17'h0_0000;
            cnt1 <= FUNCTION_PIN[1] ? cnt1 + 17'h0_0001 : 17'h0_0000;
        end
    end
    ////////////////////////////////////////
    sequence req_wait;
        OUT_REQUEST && !OUT_ACKNOWLEDGE;
    endsequence
    bus_okay_a: assert property (HREADYOUT && !HRESP)
        else $error("bus not ready or not okay");
    pulse_width_a: assert property ($fell(FUNCTION_PIN[0]) |-> cnt == {1'b0, wid} + 17'h0_0001)
        else $error("pulse width wrong");
    pin1_width_a: assert property ($fell(FUNCTION_PIN[1]) |-> cnt1 == {1'b0, wid} + 17'h0_0001)
        else $error("second pin pulse width wrong");
    pin_flag_a: assert property ($rose(FUNCTION_PIN[0]) |-> PATTERN_IRQ || COS_IRQ)
        else $error("pulse without flag");
    pat_sticky_a: assert property ($fell(PATTERN_IRQ) |-> $past(clr_p, 2))
        else $error("pattern flag dropped alone");
    cos_sticky_a: assert property ($fell(COS_IRQ) |-> $past(clr_c, 2))
        else $error("change flag dropped alone");
    in_ack_a: assert property (IN_ACKNOWLEDGE |-> $past(IN_REQUEST))
        else $error("acknowledge without request");
    in_drop_a: assert property (!IN_REQUEST |=> !IN_ACKNOWLEDGE)
        else $error("acknowledge held too long");
    out_hold_a: assert property (req_wait |=> OUT_REQUEST)
        else $error("output request dropped early");
    out_start_a: assert property ($rose(OUT_REQUEST) |-> $past(out_wr))
        else $error("output request without write");
endmodule
bind pattern_match_cos_event_unit evt_sva evt_sva_inst (.CLK, .RESETN, .HADDR, .HTRANS, .HWRITE,
    .HWDATA, .HSEL, .HREADY, .HREADYOUT, .HRESP, .FUNCTION_PIN, .PATTERN_IRQ, .COS_IRQ,
    .IN_REQUEST, .IN_ACKNOWLEDGE, .OUT_REQUEST, .OUT_ACKNOWLEDGE);

/* File: tb/evt_peer.sv */
// Peer device model: raises input requests, acknowledges output requests
module evt_peer (
    input wire logic clk,
    input wire logic resetn,
    input wire logic send,
    input wire logic [3:0] dly,
    input wire logic in_ack,
    input wire logic out_req,
    output logic in_req,
    output logic trig,
    output logic out_ack
);
    logic [1:0] st;
    logic [3:0] cnt;
    // Trigger first, so the request is not lost before the unit runs
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st <= 2'h0;
            in_req <= 1'b0;
            trig <= 1'b0;
        end else begin
            trig <= send && st == 2'h0;
            if (st == 2'h0 && send)
                st <= 2'h1;
            if (st == 2'h1) begin
                in_req <= 1'b1;
                st <= 2'h2;
            end
            if (st == 2'h2 && in_ack) begin
                in_req <= 1'b0;
                st <= 2'h0;
            end
        end
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt <= 4'h0;
            out_ack <= 1'b0;
        end else if (out_req && !out_ack) begin
            cnt <= cnt + 4'h1;
            if (cnt >= dly)
                out_ack <= 1'b1;
        end else if (!out_req) begin
            cnt <= 4'h0;
            out_ack <= 1'b0;
        end
    end
endmodule

/* File: tb/tb_pattern_match_cos_event_unit.sv */
// Testbench: register access, event pulses, flags and handshakes
module tb_pattern_match_cos_event_unit;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    logic hsel = 1'b0;
    logic [31:0] din = 32'h0000_0000;
    logic send = 1'b0;
    logic [3:0] dly = 4'h0;
    logic [31:0] hrdata;
    logic [31:0] w;
    logic [1:0] fp;
    logic hrdy, hresp, pirq, cirq, in_req, in_ack, trig, out_req, out_ack;
    int n_errors = 0;
    int samples_checked = 0;
    logic ack_seen = 1'b0;
    always #12.5 clk = ~clk;
    // Remembers that the unit answered a peer request at least once
    always @(posedge clk) begin
        if (in_ack === 1'b1)
            ack_seen <= 1'b1;
    end
    pattern_match_cos_event_unit pattern_match_cos_event_unit_inst (.CLK(clk), .RESETN(resetn),
        .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
        .HSEL(hsel), .HREADY(hrdy), .HRDATA(hrdata), .HREADYOUT(hrdy), .HRESP(hresp),
        .DATA_IN(din), .FUNCTION_PIN(fp), .PATTERN_IRQ(pirq), .COS_IRQ(cirq),
        .IN_REQUEST(in_req), .IN_ACKNOWLEDGE(in_ack), .IN_HANDSHAKE_TRIGGER(trig),
        .OUT_REQUEST(out_req), .OUT_ACKNOWLEDGE(out_ack));
    evt_peer evt_peer_inst (.clk(clk), .resetn(resetn), .send(send), .dly(dly), .in_ack(in_ack),
        .out_req(out_req), .in_req(in_req), .trig(trig), .out_ack(out_ack));
    ////////////////////////////////////////
    task automatic conclude;
        $display("checked %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            n_errors++;
            $display("Error %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic xf(input logic wt, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
        int n = 0;
        hsel <= 1'b1;
        htrans <= evt_pkg::HTRANS_NONSEQ;
        hwrite <= wt;
        haddr <= {24'h00_0000, a};
        do begin @(posedge clk); n++; end while (hrdy !== 1'b1 && n < 50);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do begin @(posedge clk); n++; end while (hrdy !== 1'b1 && n < 50);
        r = hrdata;
        if (n >= 50) begin
            n_errors++;
            $display("Error %0t: bus wait timed out", $time);
            conclude;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xf(1'b1, a, d, w);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        xf(1'b0, a, 32'h0000_0000, w);
        chk(w & m, e);
    endtask
    task automatic pl(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        int n = 0;
        do begin xf(1'b0, a, 32'h0000_0000, w); n++; end while ((w & m) !== e && n < 40);
        chk(w & m, e);
        if ((w & m) !== e)
            conclude;
    endtask
    // Counts the cycles one pin stays high after its next rise
    task automatic pw(input int b, output logic [31:0] q);
        int n = 0;
        q = 32'h0000_0000;
        while (fp[b] !== 1'b1 && n < 40) begin @(posedge clk); n++; end
        while (fp[b] === 1'b1 && n < 200) begin @(posedge clk); n++; q++; end
        if (n >= 200 || q == 32'h0000_0000) begin
            n_errors++;
            $display("Error %0t: pulse missing or too long on pin %0d", $time, b);
            conclude;
        end
    endtask
    task automatic dv(input logic [31:0] v);
        din <= v;
        repeat (4) @(posedge clk);
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        rc(evt_pkg::OFF_WIDTH, 32'h0000_FFFF, 32'h0000_0001);
        rc(evt_pkg::OFF_STATUS, 32'hFFFF_FFFF, 32'h0000_0000);
        wr(8'h3C, 32'hFFFF_FFFF);
        rc(8'h3C, 32'hFFFF_FFFF, 32'h0000_0000);
        $display("reset test done");
        wr(evt_pkg::OFF_CH_EN, 32'h0000_000F);
        wr(evt_pkg::OFF_PAT_LVL, 32'h0000_001F);
        wr(evt_pkg::OFF_PAT_EDGE, 32'h0000_000C);
        wr(evt_pkg::OFF_PAT_VAL, 32'h0000_0015);
        wr(evt_pkg::OFF_COS_EN, 32'h0000_0100);
        wr(evt_pkg::OFF_WIDTH, 32'h0000_0003);
        wr(evt_pkg::OFF_CTRL, 32'h0000_000E);
        dv(32'h0000_0009);
        dv(32'h0000_0001);
        dv(32'h0000_0009);
        rc(evt_pkg::OFF_STATUS, 32'hFFFF_FFFF, 32'h0000_0000);
        din <= 32'h0000_0005;
        pw(0, w);
        chk(w, 32'h0000_0004);
        rc(evt_pkg::OFF_STATUS, 32'hFFFF_FFFF, 32'h0000_0001);
        chk(32'(pirq), 32'h0000_0001);
        wr(evt_pkg::OFF_STATUS, 32'h0000_0003);
        rc(evt_pkg::OFF_STATUS, 32'hFFFF_FFFF, 32'h0000_0000);
        din <= 32'h0000_0105;
        pw(1, w);
        chk(w, 32'h0000_0004);
        rc(evt_pkg::OFF_STATUS, 32'hFFFF_FFFF, 32'h0000_0002);
        chk(32'(cirq), 32'h0000_0001);
        rc(evt_pkg::OFF_COS_LATCH, 32'hFFFF_FFFF, 32'h0000_0105);
        wr(evt_pkg::OFF_STATUS, 32'h0000_0003);
        dv(32'h0000_0305);
        rc(evt_pkg::OFF_STATUS, 32'hFFFF_FFFF, 32'h0000_0000);
        wr(evt_pkg::OFF_WIDTH, 32'h0000_0000);
        din <= 32'h0000_0205;
        @(posedge clk);
        din <= 32'h0000_0305;
        pw(1, w);
        chk(w, 32'h0000_0002);
        rc(evt_pkg::OFF_COS_LATCH, 32'hFFFF_FFFF, 32'h0000_0305);
        $display("event test done");
        wr(evt_pkg::OFF_CTRL, 32'h0000_001E);
        send <= 1'b1;
        @(posedge clk);
        send <= 1'b0;
        pl(evt_pkg::OFF_STATUS, 32'h0000_0004, 32'h0000_0004);
        chk(32'(ack_seen), 32'h0000_0001);
        rc(evt_pkg::OFF_INPUTS, 32'hFFFF_FFFF, 32'h0000_0305);
        chk(32'(in_ack), 32'h0000_0000);
        dly <= 4'h3;
        wr(evt_pkg::OFF_CTRL, 32'h0000_006E);
        wr(evt_pkg::OFF_INPUTS, 32'h0000_1234);
        rc(evt_pkg::OFF_STATUS, 32'h0000_0008, 32'h0000_0008);
        pl(evt_pkg::OFF_STATUS, 32'h0000_0008, 32'h0000_0000);
        $display("handshake test done");
        conclude;
    end
endmodule
